// >>> accel_i2c_slave_port.sv
// Two-wire slave port of the accelerometer with register access strobes
//
// Contract
// - Enable low: shutdown, ignore bus, never clamp either line.
// - Device is slave only; never makes START, STOP or clock.
// - START is data falling while clock high; bus then busy.
// - STOP is data rising while clock high; ends every transfer.
// - First byte after START is address plus direction; respond on match.
// - Ninth clock: transmitter releases data, receiver holds it low.
// - Any number of bytes; receiver may stretch clock, transmitter waits.
// - Address 0011100 with select pin low, 0011101 with it high.
// - Repeated START switches to read and is accepted without STOP.
// - Single read: write pointer, repeated START, read one byte, no-ack.
// - Returned data bytes go out most significant bit first.
// - Burst read advances pointer after each acknowledged byte until no-ack.
// - Single write stores one data byte at the addressed register.
// - Burst write acknowledges and stores bytes at incrementing addresses.
// - Interrupt output rises when new acceleration data is available.
// - Works at 400 kHz fast mode and 100 kHz normal mode.
// - Idle bus: both lines high, nobody driving them low.
`timescale 1ns/100ps
`include "accel_i2c_defs.svh"
module accel_i2c_slave_port (
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic EN_IN,
    input wire logic ADDR_SELECT_PIN_IN,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic [7:0] REG_RDATA_IN,
    input wire logic DATA_READY_IN,
    output logic [7:0] REG_ADDR_OUT,
    output logic [7:0] REG_WDATA_OUT,
    output logic REG_WR_OUT,
    output logic REG_RD_OUT,
    output logic INT_OUT,
    output logic LOW_POWER_OUT
);
    accel_i2c_pkg::pins_t pins_raw;
    accel_i2c_pkg::pins_t pins;
    accel_i2c_pkg::bus_cond_t cond;
    accel_i2c_pkg::state_t state_reg;
    accel_i2c_pkg::byte_kind_t kind_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic rw_reg;
    logic sda_oe_reg;
    logic scl_oe_reg;
    logic rd_reg;
    logic wr_reg;
    logic [7:0] reg_addr_reg;
    logic [7:0] wdata_reg;
    logic int_reg;
    logic low_power_reg;

    logic active;
    logic go_start;
    logic go_stop;
    logic rx_end;
    logic addr_hit;
    logic addr_miss;
    logic ack_end;
    logic read_begin;
    logic tx_fall;
    logic tx_last;
    logic m_ack;
    logic m_nack;
    logic txack_end;
    logic load_tx;

    function automatic logic addr_match(input logic [7:0] b, input logic sel);
        addr_match = (b[7:1] == {`SLAVE_ADDR_HI, sel});
    endfunction

    assign pins_raw.en = EN_IN;
    assign pins_raw.addr_select_pin = ADDR_SELECT_PIN_IN;
    assign pins_raw.sda = SDA_IN;
    assign pins_raw.scl = SCL_IN;

    // Sampling at 50 MHz leaves ample margin at the fastest bus rate
    accel_i2c_pin_sync u_sync (
        .clk_in(REF_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .pins_in(pins_raw),
        .pins_out(pins)
    );

    accel_i2c_bus_cond u_cond (
        .clk_in(REF_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .pins_in(pins),
        .cond_out(cond)
    );

    assign active = pins.en;
    assign go_start = active & cond.start;
    assign go_stop = active & cond.stop;
    assign rx_end = active & (state_reg == accel_i2c_pkg::ST_RX) & cond.scl_fall
        & (bit_cnt_reg == `RX_LAST_CNT);
    assign addr_hit = rx_end & (kind_reg == accel_i2c_pkg::KIND_ADDR)
        & addr_match(shift_reg, pins.addr_select_pin);
    assign addr_miss = rx_end & (kind_reg == accel_i2c_pkg::KIND_ADDR)
        & !addr_match(shift_reg, pins.addr_select_pin);
    assign ack_end = active & (state_reg == accel_i2c_pkg::ST_ACK) & cond.scl_fall;
    assign read_begin = (kind_reg == accel_i2c_pkg::KIND_ADDR) & rw_reg;
    assign tx_fall = active & (state_reg == accel_i2c_pkg::ST_TX) & cond.scl_fall;
    assign tx_last = tx_fall & (bit_cnt_reg == `TX_LAST_CNT);
    assign m_ack = active & (state_reg == accel_i2c_pkg::ST_TX_ACK) & cond.scl_rise
        & !pins.sda;
    assign m_nack = active & (state_reg == accel_i2c_pkg::ST_TX_ACK) & cond.scl_rise
        & pins.sda;
    assign txack_end = active & (state_reg == accel_i2c_pkg::ST_TX_ACK) & cond.scl_fall;
    assign load_tx = (ack_end & read_begin) | txack_end;
    assign ptr_next = 8'(ptr_reg + `PTR_STEP);

    // Byte sequencing
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            state_reg <= accel_i2c_pkg::ST_IDLE;
            kind_reg <= accel_i2c_pkg::KIND_ADDR;
            bit_cnt_reg <= `BIT_CNT_RESET;
            shift_reg <= `BYTE_RESET;
            rw_reg <= 1'h0;
        end
        else if (!active)
        begin
            state_reg <= accel_i2c_pkg::ST_IDLE;
        end
        else if (go_start)
        begin
            state_reg <= accel_i2c_pkg::ST_RX;
            kind_reg <= accel_i2c_pkg::KIND_ADDR;
            bit_cnt_reg <= `BIT_CNT_RESET;
        end
        else if (go_stop)
        begin
            state_reg <= accel_i2c_pkg::ST_IDLE;
        end
        else
        begin
            unique case (state_reg)
                accel_i2c_pkg::ST_IDLE:
                begin
                    bit_cnt_reg <= `BIT_CNT_RESET;
                end
                accel_i2c_pkg::ST_RX:
                begin
                    if (cond.scl_rise && bit_cnt_reg != `RX_LAST_CNT)
                    begin
                        shift_reg <= {shift_reg[6:0], pins.sda};
                        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                    end
                    else if (rx_end)
                    begin
                        if (addr_miss)
                        begin
                            state_reg <= accel_i2c_pkg::ST_IDLE;
                        end
                        else
                        begin
                            state_reg <= accel_i2c_pkg::ST_ACK;
                        end
                        if (kind_reg == accel_i2c_pkg::KIND_ADDR)
                        begin
                            rw_reg <= shift_reg[0];
                        end
                    end
                end
                accel_i2c_pkg::ST_ACK:
                begin
                    if (cond.scl_fall)
                    begin
                        bit_cnt_reg <= `BIT_CNT_RESET;
                        if (read_begin)
                        begin
                            state_reg <= accel_i2c_pkg::ST_TX;
                            shift_reg <= REG_RDATA_IN;
                        end
                        else
                        begin
                            state_reg <= accel_i2c_pkg::ST_RX;
                            kind_reg <= (kind_reg == accel_i2c_pkg::KIND_ADDR)
                                ? accel_i2c_pkg::KIND_PTR : accel_i2c_pkg::KIND_DATA;
                        end
                    end
                end
                accel_i2c_pkg::ST_TX:
                begin
                    if (tx_last)
                    begin
                        state_reg <= accel_i2c_pkg::ST_TX_ACK;
                    end
                    else if (tx_fall)
                    begin
                        shift_reg <= {shift_reg[6:0], 1'h0};
                        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                    end
                end
                accel_i2c_pkg::ST_TX_ACK:
                begin
                    if (m_nack)
                    begin
                        state_reg <= accel_i2c_pkg::ST_IDLE;
                    end
                    else if (cond.scl_fall)
                    begin
                        state_reg <= accel_i2c_pkg::ST_TX;
                        shift_reg <= REG_RDATA_IN;
                        bit_cnt_reg <= `BIT_CNT_RESET;
                    end
                end
                default:
                begin
                    state_reg <= accel_i2c_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data line drive; open drain, so only ever pulled low
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            sda_oe_reg <= 1'h0;
        end
        else if (!active || go_start || go_stop || addr_miss)
        begin
            sda_oe_reg <= 1'h0;
        end
        else if (rx_end)
        begin
            sda_oe_reg <= 1'h1;
        end
        else if (load_tx)
        begin
            sda_oe_reg <= !REG_RDATA_IN[7];
        end
        else if (ack_end || tx_last)
        begin
            sda_oe_reg <= 1'h0;
        end
        else if (tx_fall)
        begin
            sda_oe_reg <= !shift_reg[6];
        end
    end

    // Slave only: the clock line is never driven, so no stretching
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            scl_oe_reg <= 1'h0;
        end
        else
        begin
            scl_oe_reg <= 1'h0;
        end
    end

    // Register pointer and access strobes
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            ptr_reg <= `PTR_RESET;
            reg_addr_reg <= `PTR_RESET;
            wdata_reg <= `BYTE_RESET;
            rd_reg <= 1'h0;
            wr_reg <= 1'h0;
        end
        else
        begin
            rd_reg <= 1'h0;
            wr_reg <= 1'h0;
            if (addr_hit && shift_reg[0])
            begin
                rd_reg <= 1'h1;
                reg_addr_reg <= ptr_reg;
            end
            else if (rx_end && kind_reg == accel_i2c_pkg::KIND_PTR)
            begin
                ptr_reg <= shift_reg;
            end
            else if (rx_end && kind_reg == accel_i2c_pkg::KIND_DATA)
            begin
                wr_reg <= 1'h1;
                reg_addr_reg <= ptr_reg;
                wdata_reg <= shift_reg;
                ptr_reg <= ptr_next;
            end
            else if (m_ack)
            begin
                rd_reg <= 1'h1;
                reg_addr_reg <= ptr_next;
                ptr_reg <= ptr_next;
            end
        end
    end

    // New-data flag; a fresh sample wins over the clearing read
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            int_reg <= 1'h0;
            low_power_reg <= 1'h1;
        end
        else
        begin
            int_reg <= DATA_READY_IN | (int_reg & !rd_reg);
            low_power_reg <= !pins.en;
        end
    end

    assign SCL_OUT = 1'h0;
    assign SCL_OE_OUT = scl_oe_reg;
    assign SDA_OUT = 1'h0;
    assign SDA_OE_OUT = sda_oe_reg;
    assign REG_ADDR_OUT = reg_addr_reg;
    assign REG_WDATA_OUT = wdata_reg;
    assign REG_WR_OUT = wr_reg;
    assign REG_RD_OUT = rd_reg;
    assign INT_OUT = int_reg;
    assign LOW_POWER_OUT = low_power_reg;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    property p_shutdown_release;
        !active |=> !SDA_OE_OUT && state_reg == accel_i2c_pkg::ST_IDLE;
    endproperty
    a_shutdown_release: assert property (p_shutdown_release)
        else $error("data line held or bus active during shutdown");

    property p_no_clock_drive;
        !SCL_OE_OUT;
    endproperty
    a_no_clock_drive: assert property (p_no_clock_drive)
        else $error("clock line driven by slave");

    property p_start_busy;
        go_start |=> state_reg == accel_i2c_pkg::ST_RX && kind_reg == accel_i2c_pkg::KIND_ADDR
            && bit_cnt_reg == `BIT_CNT_RESET && !SDA_OE_OUT;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start condition did not open an address byte");

    property p_stop_idle;
        go_stop |=> state_reg == accel_i2c_pkg::ST_IDLE ##1 !SDA_OE_OUT;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop condition did not return to idle");

    property p_match_ack;
        addr_hit |=> state_reg == accel_i2c_pkg::ST_ACK && SDA_OE_OUT;
    endproperty
    a_match_ack: assert property (p_match_ack)
        else $error("matching address not acknowledged");

    property p_miss_ignore;
        addr_miss |=> state_reg == accel_i2c_pkg::ST_IDLE && !SDA_OE_OUT;
    endproperty
    a_miss_ignore: assert property (p_miss_ignore)
        else $error("foreign address not ignored");

    property p_ack_hold;
        state_reg == accel_i2c_pkg::ST_ACK && $past(state_reg) == accel_i2c_pkg::ST_ACK
            && active && !cond.start && !cond.stop |-> SDA_OE_OUT;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("acknowledge released early");

    property p_tx_release;
        state_reg == accel_i2c_pkg::ST_TX_ACK && $past(state_reg) == accel_i2c_pkg::ST_TX_ACK
            |-> !SDA_OE_OUT;
    endproperty
    a_tx_release: assert property (p_tx_release)
        else $error("data line not released for master acknowledge");

    property p_msb_first;
        state_reg == accel_i2c_pkg::ST_TX && $stable(state_reg) && $stable(shift_reg)
            |-> SDA_OE_OUT == !shift_reg[7];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("transmitted bit is not the byte's top bit");

    property p_write_store;
        rx_end && kind_reg == accel_i2c_pkg::KIND_DATA |=> REG_WR_OUT
            && REG_WDATA_OUT == $past(shift_reg) && ptr_reg == 8'(REG_ADDR_OUT + `PTR_STEP);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("write byte not stored or pointer not advanced");

    property p_burst_read;
        m_ack |=> REG_RD_OUT && REG_ADDR_OUT == 8'($past(ptr_reg) + `PTR_STEP);
    endproperty
    a_burst_read: assert property (p_burst_read)
        else $error("acknowledged read did not fetch next register");

    property p_data_ready;
        DATA_READY_IN |=> INT_OUT;
    endproperty
    a_data_ready: assert property (p_data_ready)
        else $error("interrupt not raised on new data");
endmodule

// >>> accel_i2c_defs.svh
// Constants of the accelerometer two-wire slave port
`ifndef ACCEL_I2C_DEFS_SVH
`define ACCEL_I2C_DEFS_SVH

// Upper six bits of the slave address; the strap pin supplies bit 0
`define SLAVE_ADDR_HI 6'h0E
// Bit counter value once a full byte has been shifted in
`define RX_LAST_CNT 4'h8
// Bit counter value while the last transmitted bit is on the line
`define TX_LAST_CNT 4'h7
`define BIT_CNT_RESET 4'h0
`define PTR_RESET 8'h00
`define BYTE_RESET 8'h00
`define PTR_STEP 8'h01
// Pin levels after reset: bus lines idle high, device disabled
`define SYNC_RESET_VEC 4'h3
// Fastest serial clock the sampling has to follow
`define REF_CLK_KHZ 50000
`define FAST_SCL_KHZ 400
`define SCL_PERIOD_CYC (`REF_CLK_KHZ / `FAST_SCL_KHZ)

`endif

// >>> accel_i2c_pkg.sv
// Types shared by the accelerometer two-wire slave port
package accel_i2c_pkg;

    typedef struct packed {
        logic en;
        logic addr_select_pin;
        logic sda;
        logic scl;
    } pins_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } bus_cond_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h2,
        ST_TX = 3'h3,
        ST_TX_ACK = 3'h4
    } state_t;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'h0,
        KIND_PTR = 2'h1,
        KIND_DATA = 2'h2
    } byte_kind_t;

endpackage

// >>> accel_i2c_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`include "accel_i2c_defs.svh"
module accel_i2c_pin_sync (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input accel_i2c_pkg::pins_t pins_in,
    output accel_i2c_pkg::pins_t pins_out
);
    localparam int W = $bits(accel_i2c_pkg::pins_t);
    localparam logic [W-1:0] RST_VEC = `SYNC_RESET_VEC;

    logic [W-1:0] raw;
    logic [W-1:0] clean_reg;

    assign raw = pins_in;
    assign pins_out = clean_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                begin
                    s1_reg <= RST_VEC[i];
                    s2_reg <= RST_VEC[i];
                    s3_reg <= RST_VEC[i];
                    clean_reg[i] <= RST_VEC[i];
                end
                else
                begin
                    s1_reg <= raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // A change counts only once two later stages agree
                    if (s2_reg == s3_reg)
                    begin
                        clean_reg[i] <= s3_reg;
                    end
                end
            end
        end
    endgenerate
endmodule

// >>> accel_i2c_bus_cond.sv
// START, STOP and clock edge detection on the cleaned bus lines
`timescale 1ns/100ps
`include "accel_i2c_defs.svh"
module accel_i2c_bus_cond (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input accel_i2c_pkg::pins_t pins_in,
    output accel_i2c_pkg::bus_cond_t cond_out
);
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            scl_prev_reg <= 1'h1;
            sda_prev_reg <= 1'h1;
        end
        else
        begin
            scl_prev_reg <= pins_in.scl;
            sda_prev_reg <= pins_in.sda;
        end
    end

    // Data edges count only with the clock high on both samples
    assign cond_out.start = pins_in.scl & scl_prev_reg & sda_prev_reg & ~pins_in.sda;
    assign cond_out.stop = pins_in.scl & scl_prev_reg & ~sda_prev_reg & pins_in.sda;
    assign cond_out.scl_rise = pins_in.scl & ~scl_prev_reg;
    assign cond_out.scl_fall = ~pins_in.scl & scl_prev_reg;
endmodule

// >>> i2c_master_model.sv
// Behavioural two-wire bus master driving open-drain lines
`timescale 1ns/100ps
module i2c_master_model (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    // Phases kept at 160 ns: the slave's sampler gets eight clocks per phase
    int half_ns = 160;
    int stall_err = 0;

    initial
    begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    // One clock pulse: data set in the low phase, sampled mid-high
    task automatic clk_bit(input logic b, output logic s);
        int n;
        begin
            sda_low_out = !b;
            #(half_ns / 2);
            scl_low_out = 1'b0;
            n = 0;
            while (scl_in !== 1'b1 && n < 1000)
            begin
                #10;
                n++;
            end
            if (n == 1000)
                stall_err++;
            #(half_ns / 2);
            s = sda_in;
            #(half_ns / 2);
            scl_low_out = 1'b1;
            #(half_ns / 2);
        end
    endtask

    // Also serves as repeated START when entered with the clock low
    task automatic start();
        begin
            sda_low_out = 1'b0;
            #(half_ns / 2);
            scl_low_out = 1'b0;
            #(half_ns);
            sda_low_out = 1'b1;
            #(half_ns);
            scl_low_out = 1'b1;
            #(half_ns / 2);
        end
    endtask

    task automatic stop();
        begin
            sda_low_out = 1'b1;
            #(half_ns / 2);
            scl_low_out = 1'b0;
            #(half_ns);
            sda_low_out = 1'b0;
            #(half_ns);
        end
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        begin
            for (int i = 7; i >= 0; i--)
                clk_bit(d[i], s);
            clk_bit(1'b1, ack);
        end
    endtask

    task automatic get_byte(input logic nak, output logic [7:0] d);
        logic s;
        begin
            for (int i = 7; i >= 0; i--)
            begin
                clk_bit(1'b1, s);
                d[i] = s;
            end
            clk_bit(nak, s);
        end
    endtask
endmodule

// >>> accel_i2c_slave_port_tb.sv
// Self-checking bench for the accelerometer two-wire slave port
`timescale 1ns/100ps
`define CHECK(nm, exp, got) \
    begin \
        checked++; \
        if ((exp) !== (got)) \
        begin \
            $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
            err_count++; \
        end \
    end
module accel_i2c_slave_port_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic en = 1'b1;
    logic sel = 1'b0;
    logic data_ready = 1'b0;
    logic [7:0] rdata = 8'h00;
    logic scl, sda, scl_o, sda_o, scl_oe, sda_oe, m_scl_low, m_sda_low;
    logic [7:0] reg_addr, wdata;
    logic reg_wr, reg_rd, int_o, low_pw;
    logic [7:0] regs [256];
    logic [7:0] wdat [4];
    logic [15:0] wr_q [$];
    logic [15:0] note;
    logic [31:0] rnd = 32'h9448A226;
    logic [31:0] tmp;
    logic [7:0] ptr;
    int oe_cnt = 0;
    int oe_base = 0;
    int err_count = 0;
    int checked = 0;

    always #10 clk = !clk;
    // Pull-ups: a line is low only while someone drives it
    assign scl = !(m_scl_low | (scl_oe & !scl_o));
    assign sda = !(m_sda_low | (sda_oe & !sda_o));

    accel_i2c_slave_port dut (
        .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .EN_IN(en), .ADDR_SELECT_PIN_IN(sel),
        .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe),
        .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
        .REG_RDATA_IN(rdata), .DATA_READY_IN(data_ready), .REG_ADDR_OUT(reg_addr),
        .REG_WDATA_OUT(wdata), .REG_WR_OUT(reg_wr), .REG_RD_OUT(reg_rd),
        .INT_OUT(int_o), .LOW_POWER_OUT(low_pw)
    );

    i2c_master_model master (
        .scl_in(scl), .sda_in(sda), .scl_low_out(m_scl_low), .sda_low_out(m_sda_low)
    );

    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    // Register file behind the strobe port, and the write-result checker
    always @(posedge clk)
    begin
        if (sda_oe === 1'b1)
            oe_cnt++;
        if (scl_oe !== 1'b0)
            `CHECK("clock drive", 1'b0, scl_oe)
        if (reg_rd === 1'b1)
            rdata <= regs[reg_addr];
        if (reg_wr === 1'b1)
        begin
            regs[reg_addr] <= wdata;
            if (wr_q.size() == 0)
                `CHECK("write strobe", 1'b0, reg_wr)
            else
            begin
                note = wr_q.pop_front();
                `CHECK("write addr data", note, {reg_addr, wdata})
            end
        end
    end

    task automatic addr_phase(input logic [6:0] a, input logic rw, input logic exp);
        logic ack;
        begin
            // Offset from the edges, so pin changes never race the synchroniser
            @(posedge clk);
            #5;
            master.start();
            master.put_byte({a, rw}, ack);
            `CHECK("address ack", exp, ack)
        end
    endtask

    task automatic write_regs(input logic [7:0] p, input int n);
        logic ack;
        begin
            addr_phase(7'h1C, 1'b0, 1'b0);
            master.put_byte(p, ack);
            `CHECK("pointer ack", 1'b0, ack)
            for (int i = 0; i < n; i++)
            begin
                tmp = xs();
                wdat[i] = tmp[7:0];
                wr_q.push_back({p + 8'(i), tmp[7:0]});
                master.put_byte(tmp[7:0], ack);
                `CHECK("data ack", 1'b0, ack)
            end
            master.stop();
        end
    endtask

    task automatic read_regs(input logic [7:0] p, input int n);
        logic ack;
        logic [7:0] d;
        begin
            addr_phase(7'h1C, 1'b0, 1'b0);
            master.put_byte(p, ack);
            `CHECK("pointer ack", 1'b0, ack)
            addr_phase(7'h1C, 1'b1, 1'b0);
            for (int i = 0; i < n; i++)
            begin
                master.get_byte(i == n - 1, d);
                `CHECK("read data", wdat[i], d)
            end
            master.stop();
        end
    endtask

    task automatic print_verdict();
        begin
            err_count += master.stall_err;
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    initial
    begin
        #1500000;
        err_count++;
        print_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (12) @(posedge clk);
        tmp = xs();
        ptr = tmp[7:0];
        write_regs(ptr, 3);
        read_regs(ptr, 3);
        read_regs(ptr, 1);
        $display("test burst write and read done");
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk);
            sel <= s[0];
            repeat (10) @(posedge clk);
            for (int a = 0; a < 2; a++)
                addr_phase(7'h1C | 7'(a), 1'b0, a != s);
            master.stop();
        end
        @(posedge clk);
        sel <= 1'b0;
        $display("test address select done");
        data_ready <= 1'b1;
        @(posedge clk);
        data_ready <= 1'b0;
        @(posedge clk);
        `CHECK("interrupt set", 1'b1, int_o)
        read_regs(ptr, 1);
        `CHECK("interrupt cleared", 1'b0, int_o)
        $display("test interrupt done");
        @(posedge clk);
        en <= 1'b0;
        repeat (10) @(posedge clk);
        `CHECK("low power", 1'b1, low_pw)
        oe_base = oe_cnt;
        addr_phase(7'h1C, 1'b0, 1'b1);
        master.stop();
        `CHECK("data drive in shutdown", oe_base, oe_cnt)
        @(posedge clk);
        en <= 1'b1;
        repeat (10) @(posedge clk);
        `CHECK("low power", 1'b0, low_pw)
        $display("test shutdown done");
        master.half_ns = 5000;
        tmp = xs();
        ptr = tmp[7:0];
        write_regs(ptr, 1);
        master.half_ns = 160;
        read_regs(ptr, 1);
        $display("test normal mode done");
        repeat (10) @(posedge clk);
        `CHECK("idle data drive", 1'b0, sda_oe)
        `CHECK("idle lines", 2'b11, {scl, sda})
        `CHECK("pending writes", 0, wr_q.size())
        print_verdict();
    end
endmodule
